// [verilog/l1_act_pkg.sv]
package l1_act_pkg;
  localparam logic [3:0] CMD_CLOCK_DEMAND = 4'h0;
  localparam logic [3:0] CMD_STATE_MACHINE_CLEAR = 4'h1;
  localparam logic [3:0] CMD_SINGLE_PULSE_TEST = 4'h2;
  localparam logic [3:0] CMD_CONTINUOUS_PULSE_TEST = 4'h3;
  localparam logic [3:0] CMD_ACTIVATE_PRIO8 = 4'h8;
  localparam logic [3:0] CMD_ACTIVATE_PRIO10 = 4'h9;
  localparam logic [3:0] CMD_LOOP_A_REQUEST = 4'hA;
  localparam logic [3:0] CMD_DEACTIVATION_CONFIRM = 4'hF;
  localparam logic [3:0] CMD_DEACT_REQUEST_LT = 4'h0;
  localparam logic [3:0] CMD_ACTIVATE_DOWNSTREAM = 4'h8;

  localparam logic [3:0] IND_DEACT_REQUEST = 4'h0;
  localparam logic [3:0] IND_STATE_MACHINE_CLEAR = 4'h1;
  localparam logic [3:0] IND_TEST_ACK = 4'h2;
  localparam logic [3:0] IND_SLIP_FLAG = 4'h3;
  localparam logic [3:0] IND_UNSYNC_SIGNAL = 4'h4;
  localparam logic [3:0] IND_DEACT_REQUEST_FROM_F6 = 4'h5;
  localparam logic [3:0] IND_POWER_UP_REPORT = 4'h7;
  localparam logic [3:0] IND_INFO2_SEEN_REPORT = 4'h8;
  localparam logic [3:0] IND_LOOP_A_CLOSED = 4'hA;
  localparam logic [3:0] IND_ILLEGAL_VIOLATION_FLAG = 4'hB;
  localparam logic [3:0] IND_ACTIVATED_PRIO8 = 4'hC;
  localparam logic [3:0] IND_ACTIVATED_PRIO10 = 4'hD;
  localparam logic [3:0] IND_LOOP_ACTIVE_REPORT = 4'hE;
  localparam logic [3:0] IND_QUIESCENT = 4'hF;
  localparam logic [3:0] IND_LT_TIMING = 4'h0;
  localparam logic [3:0] IND_LT_ACTIVATION = 4'h8;
  localparam logic [3:0] IND_LT_ACTIVATED = 4'hC;
  localparam logic [3:0] IND_DEACTIVATED_NOTICE = 4'hF;

  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned FRAME_HZ = 4000;
  localparam int unsigned FRAME_CYCLES = CLK_HZ / FRAME_HZ;
  localparam int unsigned INFO0_PERSIST_MS = 16;
  localparam int unsigned DEACT_TIMEOUT_MS = 32;
  localparam int unsigned INFO0_PERSIST_CYCLES = INFO0_PERSIST_MS * (CLK_HZ / 1000);
  localparam int unsigned DEACT_TIMEOUT_CYCLES = DEACT_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned CI_STABLE_FRAMES = 2;
  localparam logic [7:0] INFO1_PATTERN = 8'h3F;

  typedef enum logic [1:0] {RX_INFO0, RX_INFO2, RX_INFO4, RX_OTHER} rx_info_e;
  typedef enum logic [2:0] {TX_INFO0, TX_INFO1, TX_INFO2, TX_INFO3, TX_INFO4,
    TX_SINGLE_PULSE, TX_CONT_PULSE} tx_info_e;

  typedef struct packed {
    rx_info_e info;
    logic sync;
    logic slip;
    logic violation;
    logic level;
  } rx_status_s;

  typedef struct packed {
    logic violation_detect_enable;
    logic clock_stop_select;
    logic loop_tx_mute;
    logic exchange_mode;
  } l1_config_s;
endpackage : l1_act_pkg

// [verilog/ci_code_filter.sv]
`timescale 1ns/1ns
module ci_code_filter #(
  parameter int unsigned STABLE_FRAMES = 2
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic frame_tick_i,
  input wire logic [3:0] code_i,
  output logic [3:0] code_o,
  output logic valid_o
);
  typedef struct packed {
    logic [3:0] last;
    logic [3:0] held;
    logic [3:0] count;
    logic valid;
  } filt_s;

  filt_s state_reg;
  filt_s state_next;

  // A code is accepted only after it repeats over consecutive frames
  always_comb
  begin
    state_next = state_reg;
    if (frame_tick_i)
    begin
      state_next.last = code_i;
      if (code_i != state_reg.last)
        state_next.count = 4'h1;
      else if (state_reg.count < 4'(STABLE_FRAMES))
        state_next.count = state_reg.count + 4'h1;
      if (code_i == state_reg.last && state_reg.count + 4'h1 >= 4'(STABLE_FRAMES))
      begin
        state_next.held = code_i;
        state_next.valid = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign code_o = state_reg.held;
  assign valid_o = state_reg.valid;

  AST_HELD_IS_REPEATED: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $changed(code_o) |-> code_o == $past(code_i, 1) && $past(frame_tick_i))
    else $error("held code changed without a frame repeat");
endmodule : ci_code_filter

// [verilog/l1_activation_fsm.sv]
`timescale 1ns/1ns
module l1_activation_fsm
  import l1_act_pkg::*;
#(
  parameter int unsigned FRAME_LEN = l1_act_pkg::FRAME_CYCLES,
  parameter int unsigned INFO0_PERSIST = l1_act_pkg::INFO0_PERSIST_CYCLES,
  parameter int unsigned DEACT_TIMEOUT = l1_act_pkg::DEACT_TIMEOUT_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] cmd_code_i,
  input wire l1_act_pkg::rx_status_s rx_status_i,
  input wire l1_act_pkg::l1_config_s config_i,
  input wire logic [7:0] user_tx_i,
  output logic [3:0] ind_code_o,
  output l1_act_pkg::tx_info_e tx_info_o,
  output logic tx_bit_o,
  output logic frame_tick_o,
  output logic clocks_on_o,
  output logic channels_through_o,
  output logic high_prio_o,
  output logic loop_closed_o,
  output logic loop_tx_mute_o
);
  import l1_act_pkg::*;

  typedef enum logic [4:0] {
    F3_PEND_DEACT, F3_DEACT, F3_POWER_UP, F4_PEND_ACT, F5_UNSYNC, F6_SYNC, F7_ACT,
    F8_LOST, LOOP_CLOSED, LOOP_ACT, TEST_SINGLE, TEST_CONT, CLEARED,
    G1_DEACT, G2_PEND_ACT, G3_ACT, G2_LOST, G4_PEND_DEACT, G4_WAIT_CONFIRM
  } l1_state_e;

  typedef struct packed {
    l1_state_e st;
    logic [19:0] frame_cnt;
    logic [31:0] info0_cnt;
    logic [31:0] deact_cnt;
    logic [2:0] bit_idx;
    logic prio10;
    logic [3:0] ind;
    tx_info_e tx;
    logic tx_bit;
    logic pulse_pol;
  } fsm_s;

  fsm_s state_reg;
  fsm_s state_next;
  logic frame_tick;
  logic [3:0] cmd;
  logic cmd_valid;
  logic act_cmd;

  function automatic logic is_activation(input logic [3:0] c);
    is_activation = (c == CMD_ACTIVATE_PRIO8) || (c == CMD_ACTIVATE_PRIO10) ||
      (c == CMD_LOOP_A_REQUEST);
  endfunction : is_activation

  assign frame_tick = (state_reg.frame_cnt == 20'(FRAME_LEN - 1));

  ci_code_filter #(
    .STABLE_FRAMES(CI_STABLE_FRAMES)
  ) u_cmd_filter (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .frame_tick_i(frame_tick),
    .code_i(cmd_code_i),
    .code_o(cmd),
    .valid_o(cmd_valid)
  );

  assign act_cmd = cmd_valid && is_activation(cmd);

  always_comb
  begin
    state_next = state_reg;
    state_next.frame_cnt = frame_tick ? 20'h0 : state_reg.frame_cnt + 20'h1;
    if (config_i.exchange_mode)
    begin
      if (cmd_valid && cmd == CMD_STATE_MACHINE_CLEAR)
        state_next.st = CLEARED;
      else if (cmd_valid && cmd == CMD_SINGLE_PULSE_TEST)
        state_next.st = TEST_SINGLE;
      else if (cmd_valid && cmd == CMD_CONTINUOUS_PULSE_TEST)
        state_next.st = TEST_CONT;
      else
      begin
        unique case (state_reg.st)
          G1_DEACT:
            if (rx_status_i.level || (cmd_valid && cmd == CMD_ACTIVATE_DOWNSTREAM))
              state_next.st = G2_PEND_ACT;
          G2_PEND_ACT, G2_LOST:
            if (cmd_valid && cmd == CMD_DEACT_REQUEST_LT)
              state_next.st = G4_PEND_DEACT;
            else if (rx_status_i.sync)
              state_next.st = G3_ACT;
          G3_ACT:
            if (cmd_valid && cmd == CMD_DEACT_REQUEST_LT)
              state_next.st = G4_PEND_DEACT;
            else if (!rx_status_i.sync)
              state_next.st = G2_LOST;
          G4_PEND_DEACT:
            // Counters start at one on entry, so the full persist/timeout spans are kept
            if (state_reg.info0_cnt >= 32'(INFO0_PERSIST) ||
                state_reg.deact_cnt >= 32'(DEACT_TIMEOUT))
              state_next.st = G4_WAIT_CONFIRM;
          G4_WAIT_CONFIRM:
            if (cmd_valid && cmd == CMD_DEACTIVATION_CONFIRM)
              state_next.st = G1_DEACT;
          default:
            if (cmd_valid && cmd == CMD_DEACTIVATION_CONFIRM)
              state_next.st = G1_DEACT;
        endcase
      end
    end
    else if (cmd_valid && cmd == CMD_STATE_MACHINE_CLEAR)
      state_next.st = CLEARED;
    else if (cmd_valid && cmd == CMD_SINGLE_PULSE_TEST)
      state_next.st = TEST_SINGLE;
    else if (cmd_valid && cmd == CMD_CONTINUOUS_PULSE_TEST)
      state_next.st = TEST_CONT;
    else if (cmd_valid && cmd == CMD_LOOP_A_REQUEST &&
             state_reg.st != LOOP_CLOSED && state_reg.st != LOOP_ACT)
      state_next.st = LOOP_CLOSED;
    else
    begin
      unique case (state_reg.st)
        CLEARED, TEST_SINGLE, TEST_CONT, F3_PEND_DEACT:
          if (cmd_valid && cmd == CMD_DEACTIVATION_CONFIRM)
            state_next.st = F3_DEACT;
        F3_DEACT, F3_POWER_UP:
          if (rx_status_i.info == RX_INFO4)
            state_next.st = F7_ACT;
          else if (rx_status_i.info == RX_INFO2)
            state_next.st = F6_SYNC;
          else if (act_cmd)
            state_next.st = F4_PEND_ACT;
          else if (cmd_valid && cmd == CMD_CLOCK_DEMAND)
            state_next.st = F3_POWER_UP;
          else if (cmd_valid && cmd == CMD_DEACTIVATION_CONFIRM)
            state_next.st = F3_DEACT;
        F4_PEND_ACT, F5_UNSYNC:
          if (rx_status_i.info == RX_INFO4)
            state_next.st = F7_ACT;
          else if (rx_status_i.info == RX_INFO2)
            state_next.st = F6_SYNC;
          else if (rx_status_i.info == RX_OTHER)
            state_next.st = F5_UNSYNC;
          else if (cmd_valid && cmd == CMD_DEACTIVATION_CONFIRM)
            state_next.st = F3_DEACT;
        F6_SYNC, F7_ACT, F8_LOST:
          if (rx_status_i.info == RX_INFO0)
            state_next.st = F3_PEND_DEACT;
          else if (rx_status_i.info == RX_INFO4)
            state_next.st = F7_ACT;
          else if (rx_status_i.info == RX_INFO2)
            state_next.st = F6_SYNC;
          else if (!rx_status_i.sync)
            state_next.st = F8_LOST;
        LOOP_CLOSED:
          if (rx_status_i.sync)
            state_next.st = LOOP_ACT;
        LOOP_ACT:
          if (!rx_status_i.sync)
            state_next.st = LOOP_CLOSED;
        default:
          state_next.st = G1_DEACT == state_reg.st ? F3_DEACT : CLEARED;
      endcase
    end

    if (cmd_valid && cmd == CMD_ACTIVATE_PRIO10)
      state_next.prio10 = 1'b1;
    else if (cmd_valid && cmd == CMD_ACTIVATE_PRIO8)
      state_next.prio10 = 1'b0;

    state_next.info0_cnt = (state_next.st == G4_PEND_DEACT && rx_status_i.info == RX_INFO0)
      ? state_reg.info0_cnt + 32'h1 : 32'h0;
    state_next.deact_cnt = (state_next.st == G4_PEND_DEACT) ? state_reg.deact_cnt + 32'h1 : 32'h0;

    unique case (state_next.st)
      CLEARED: state_next.ind = IND_STATE_MACHINE_CLEAR;
      TEST_SINGLE, TEST_CONT: state_next.ind = IND_TEST_ACK;
      F3_DEACT: state_next.ind = IND_QUIESCENT;
      F3_POWER_UP: state_next.ind = IND_POWER_UP_REPORT;
      F3_PEND_DEACT:
        state_next.ind = (state_reg.st == F6_SYNC) ? IND_DEACT_REQUEST_FROM_F6 :
          (state_reg.st == F3_PEND_DEACT) ? state_reg.ind : IND_DEACT_REQUEST;
      F4_PEND_ACT: state_next.ind = IND_POWER_UP_REPORT;
      F5_UNSYNC, F8_LOST: state_next.ind = IND_UNSYNC_SIGNAL;
      F6_SYNC: state_next.ind = IND_INFO2_SEEN_REPORT;
      F7_ACT:
        state_next.ind = state_next.prio10 ? IND_ACTIVATED_PRIO10 : IND_ACTIVATED_PRIO8;
      LOOP_CLOSED: state_next.ind = IND_LOOP_A_CLOSED;
      LOOP_ACT:
        state_next.ind = (rx_status_i.level && !config_i.loop_tx_mute) ? IND_UNSYNC_SIGNAL :
          IND_LOOP_ACTIVE_REPORT;
      G1_DEACT: state_next.ind = IND_DEACTIVATED_NOTICE;
      G2_PEND_ACT: state_next.ind = IND_LT_ACTIVATION;
      G3_ACT: state_next.ind = IND_LT_ACTIVATED;
      G2_LOST: state_next.ind = IND_UNSYNC_SIGNAL;
      G4_PEND_DEACT: state_next.ind = IND_LT_TIMING;
      G4_WAIT_CONFIRM: state_next.ind = IND_DEACTIVATED_NOTICE;
    endcase
    // Slip reports (outside exchange mode) and enabled violation reports override steady indications in each cycle they are present
    if (rx_status_i.slip && !config_i.exchange_mode)
      state_next.ind = IND_SLIP_FLAG;
    if (rx_status_i.violation && config_i.violation_detect_enable)
      state_next.ind = IND_ILLEGAL_VIOLATION_FLAG;

    unique case (state_next.st)
      F4_PEND_ACT: state_next.tx = TX_INFO1;
      F6_SYNC, F7_ACT, F8_LOST, LOOP_CLOSED, LOOP_ACT: state_next.tx = TX_INFO3;
      TEST_SINGLE: state_next.tx = TX_SINGLE_PULSE;
      TEST_CONT: state_next.tx = TX_CONT_PULSE;
      G2_PEND_ACT, G2_LOST: state_next.tx = TX_INFO2;
      G3_ACT: state_next.tx = TX_INFO4;
      default: state_next.tx = TX_INFO0;
    endcase

    state_next.bit_idx = state_reg.bit_idx + 3'h1;
    if (frame_tick)
      state_next.pulse_pol = ~state_reg.pulse_pol;
    unique case (state_reg.tx)
      TX_INFO1: state_next.tx_bit = INFO1_PATTERN[3'h7 - state_reg.bit_idx];
      TX_SINGLE_PULSE: state_next.tx_bit = frame_tick;
      TX_CONT_PULSE: state_next.tx_bit = 1'b1;
      TX_INFO3, TX_INFO2, TX_INFO4:
        state_next.tx_bit = channels_through_o ? user_tx_i[state_reg.bit_idx] : 1'b1;
      default: state_next.tx_bit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= '0;
      state_reg.st <= CLEARED;
      state_reg.ind <= IND_STATE_MACHINE_CLEAR;
    end
    else
      state_reg <= state_next;
  end

  assign ind_code_o = state_reg.ind;
  assign tx_info_o = state_reg.tx;
  assign tx_bit_o = state_reg.tx_bit;
  assign frame_tick_o = frame_tick;
  assign high_prio_o = state_reg.prio10;
  assign loop_closed_o = (state_reg.st == LOOP_CLOSED) || (state_reg.st == LOOP_ACT);
  assign loop_tx_mute_o = loop_closed_o && config_i.loop_tx_mute;
  // Clocks stop only in deactivated state F3_DEACT or G1_DEACT with stop selected
  assign clocks_on_o = !((state_reg.st == F3_DEACT || state_reg.st == G1_DEACT) &&
    config_i.clock_stop_select);
  assign channels_through_o = (((state_reg.st == F7_ACT) && rx_status_i.sync) ||
    state_reg.st == LOOP_ACT || state_reg.st == G3_ACT) &&
    (config_i.exchange_mode || act_cmd);

  AST_CLEAR_ACK: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (cmd_valid && cmd == CMD_STATE_MACHINE_CLEAR && !config_i.exchange_mode &&
     !rx_status_i.violation && !rx_status_i.slip) |=> ind_code_o == IND_STATE_MACHINE_CLEAR)
    else $error("clear not acknowledged");
  AST_TEST_ACK: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (tx_info_o == TX_CONT_PULSE || tx_info_o == TX_SINGLE_PULSE) && !$past(rx_status_i.slip) &&
    !$past(rx_status_i.violation) |-> ind_code_o == IND_TEST_ACK)
    else $error("test ack missing");
  AST_CONT_PULSE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    tx_info_o == TX_CONT_PULSE ##1 tx_info_o == TX_CONT_PULSE |-> tx_bit_o)
    else $error("continuous pulses missing");
  AST_THROUGH_NEEDS_ACT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    channels_through_o && !config_i.exchange_mode |-> cmd_valid &&
    (cmd == CMD_ACTIVATE_PRIO8 || cmd == CMD_ACTIVATE_PRIO10 || cmd == CMD_LOOP_A_REQUEST))
    else $error("channels through without activation command");
  AST_VIOL_GATED: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ind_code_o == IND_ILLEGAL_VIOLATION_FLAG && !loop_closed_o && tx_info_o != TX_INFO0 |->
    $past(config_i.violation_detect_enable))
    else $error("violation reported while disabled");
  AST_CLOCK_STOP: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !clocks_on_o |-> config_i.clock_stop_select && ind_code_o != IND_POWER_UP_REPORT)
    else $error("clock stopped wrongly");
  AST_LT_INFO2: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    config_i.exchange_mode && state_reg.st == G3_ACT && !rx_status_i.sync &&
    !(cmd_valid && (cmd == CMD_DEACT_REQUEST_LT || cmd == CMD_STATE_MACHINE_CLEAR ||
    cmd == CMD_SINGLE_PULSE_TEST || cmd == CMD_CONTINUOUS_PULSE_TEST))
    |=> tx_info_o == TX_INFO2)
    else $error("no fallback to INFO 2");
  AST_DEACT_TIMEOUT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg.st == G4_PEND_DEACT |-> state_reg.deact_cnt <= 32'(DEACT_TIMEOUT))
    else $error("deactivation timer overran");
  AST_WAIT_CONFIRM: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg.st == G4_WAIT_CONFIRM && config_i.exchange_mode && !(cmd_valid &&
    (cmd == CMD_DEACTIVATION_CONFIRM || cmd == CMD_STATE_MACHINE_CLEAR ||
     cmd == CMD_SINGLE_PULSE_TEST || cmd == CMD_CONTINUOUS_PULSE_TEST))
    |=> state_reg.st == G4_WAIT_CONFIRM)
    else $error("left final wait without confirm");
  AST_INFO2_IND: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg.st == F6_SYNC && !rx_status_i.slip && !rx_status_i.violation |->
    ind_code_o == IND_INFO2_SEEN_REPORT || $past(rx_status_i.slip) || $past(rx_status_i.violation))
    else $error("INFO 2 not reported");

  COV_TE_ACTIVATED: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg.st == F4_PEND_ACT ##[1:20] state_reg.st == F7_ACT);
  COV_LOOP: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg.st == LOOP_ACT);
  COV_LT_DEACT: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg.st == G4_PEND_DEACT ##1 state_reg.st == G4_WAIT_CONFIRM);
endmodule : l1_activation_fsm

// [bench/line_partner_model.sv]
`timescale 1ns/1ns
module line_partner_model
  import l1_act_pkg::*;
(
  input wire l1_act_pkg::rx_info_e info_i,
  input wire logic sync_i,
  input wire logic slip_i,
  input wire logic violation_i,
  output l1_act_pkg::rx_status_s rx_status_o
);
  import l1_act_pkg::*;

  // A silent line carries no code violations, so they only show with level
  always_comb
  begin
    rx_status_o.info = info_i;
    rx_status_o.level = (info_i != RX_INFO0);
    rx_status_o.sync = sync_i;
    rx_status_o.slip = slip_i;
    rx_status_o.violation = violation_i && (info_i != RX_INFO0);
  end
endmodule : line_partner_model

// [bench/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  import l1_act_pkg::*;
  localparam int FL = 50;
  typedef struct {int ex; int cmd; int info; int sy; int sl; int vi; int ve;
    int ind; int tx; int fl; int fm;} step_s;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] cmd_code = 4'h1;
  rx_status_s rx_status;
  l1_config_s cfg = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic [7:0] user_tx = 8'h00;
  logic [3:0] ind_code;
  tx_info_e tx_info;
  logic tx_bit;
  logic frame_tick;
  logic clocks_on;
  logic chan_through;
  logic high_prio;
  logic loop_closed;
  logic loop_mute;
  rx_info_e line_info = RX_INFO0;
  logic line_sync = 1'b0;
  logic line_slip = 1'b0;
  logic line_viol = 1'b0;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 32'h428f;
  int t0;
  step_s steps[$];

  l1_activation_fsm #(.FRAME_LEN(FL), .INFO0_PERSIST(16), .DEACT_TIMEOUT(32)) l1_activation_fsm_i (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cmd_code_i(cmd_code),
    .rx_status_i(rx_status), .config_i(cfg), .user_tx_i(user_tx),
    .ind_code_o(ind_code), .tx_info_o(tx_info), .tx_bit_o(tx_bit),
    .frame_tick_o(frame_tick), .clocks_on_o(clocks_on),
    .channels_through_o(chan_through), .high_prio_o(high_prio),
    .loop_closed_o(loop_closed), .loop_tx_mute_o(loop_mute));

  line_partner_model line_partner_model_i (.info_i(line_info), .sync_i(line_sync),
    .slip_i(line_slip), .violation_i(line_viol), .rx_status_o(rx_status));

  initial
  begin
    forever #25 core_clk_i = ~core_clk_i;
  end

  // Payload bits are kept moving so the pass-through path never sits idle
  always @(negedge core_clk_i)
  begin
    user_tx = 8'($random(seed));
  end

  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // Codes are only taken after two equal frame samples, so three frames are waited
  task automatic run_step(input int n, input step_s s);
    logic [4:0] flags;
    logic [15:0] bits;
    if (s.ex != int'(cfg.exchange_mode))
    begin
      cfg.exchange_mode = s.ex[0];
      rst_n_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      rst_n_i = 1'b1;
    end
    cmd_code = s.cmd[3:0];
    line_info = rx_info_e'(s.info[1:0]);
    line_sync = s.sy[0];
    line_slip = s.sl[0];
    line_viol = s.vi[0];
    cfg.violation_detect_enable = s.ve[0];
    repeat (3 * FL + 2) @(negedge core_clk_i);
    flags = {clocks_on, chan_through, high_prio, loop_closed, loop_mute};
    if (s.ind >= 0)
      check({4'h0, ind_code}, 8'(s.ind), "indication");
    if (s.tx >= 0)
      check({5'h00, tx_info}, 8'(s.tx), "line info");
    check({3'h0, flags & s.fm[4:0]}, {3'h0, s.fl[4:0] & s.fm[4:0]}, "flags");
    // Line bits are looked at only where the rules fix them: INFO 1 and continuous pulses
    if (s.tx == 1 || s.tx == 6)
    begin
      bits = 16'h0000;
      repeat (16)
      begin
        @(negedge core_clk_i);
        bits = {bits[14:0], tx_bit};
      end
      if (s.tx == 1)
        check({7'h00, bits[15:8] == bits[7:0]}, 8'h01, "info1 period");
      if (s.tx == 1)
        check(8'($countones(bits[7:0])), 8'h06, "info1 ones");
      if (s.tx == 6)
        check(bits[7:0], 8'hFF, "continuous pulses");
    end
    $display("step %0d done", n);
  endtask : run_step

  initial
  begin
    steps.push_back('{0, 4'h2, 0, 0, 0, 0, 0, 4'h2, 5, 0, 0});
    steps.push_back('{0, 4'h3, 0, 0, 0, 0, 0, 4'h2, 6, 0, 0});
    steps.push_back('{0, 4'h1, 0, 0, 0, 0, 0, 4'h1, 0, 0, 0});
    steps.push_back('{0, 4'hF, 0, 0, 0, 0, 0, 4'hF, 0, 5'h00, 5'h10});
    steps.push_back('{0, 4'h0, 0, 0, 0, 0, 0, 4'h7, 0, 5'h10, 5'h10});
    steps.push_back('{0, 4'h8, 0, 0, 0, 0, 0, 4'h7, 1, 0, 0});
    steps.push_back('{0, 4'h8, 1, 1, 0, 0, 0, 4'h8, 3, 0, 0});
    steps.push_back('{0, 4'h8, 2, 1, 0, 0, 0, 4'hC, 3, 5'h18, 5'h1C});
    steps.push_back('{0, 4'h8, 2, 1, 1, 0, 0, 4'h3, 3, 0, 0});
    steps.push_back('{0, 4'h8, 2, 1, 0, 1, 0, 4'hC, 3, 0, 0});
    steps.push_back('{0, 4'h8, 2, 1, 0, 1, 1, 4'hB, 3, 0, 0});
    steps.push_back('{0, 4'h9, 2, 1, 0, 0, 0, 4'hD, 3, 5'h1C, 5'h1C});
    steps.push_back('{0, 4'h0, 2, 1, 0, 0, 0, -1, -1, 5'h00, 5'h08});
    steps.push_back('{0, 4'h0, 0, 0, 0, 0, 0, 4'h0, 0, 0, 0});
    steps.push_back('{0, 4'h1, 0, 0, 0, 0, 0, 4'h1, 0, 0, 0});
    steps.push_back('{0, 4'hA, 0, 0, 0, 0, 0, 4'hA, 3, 5'h03, 5'h03});
    steps.push_back('{0, 4'hA, 0, 1, 0, 0, 0, 4'hE, -1, 5'h02, 5'h02});
    steps.push_back('{1, 4'hF, 0, 0, 0, 0, 0, 4'hF, 0, 5'h00, 5'h10});
    steps.push_back('{1, 4'h8, 0, 0, 0, 0, 0, 4'h8, 2, 0, 0});
    steps.push_back('{1, 4'h8, 3, 1, 0, 0, 0, 4'hC, 4, 0, 0});
    steps.push_back('{1, 4'h8, 3, 0, 0, 0, 0, 4'h4, 2, 0, 0});
    steps.push_back('{1, 4'h8, 3, 1, 0, 0, 0, 4'hC, 4, 0, 0});
    steps.push_back('{1, 4'h0, 0, 0, 0, 0, 0, 4'hF, 0, 0, 0});
    steps.push_back('{1, 4'h0, 0, 0, 0, 0, 0, 4'hF, 0, 5'h10, 5'h10});
    steps.push_back('{1, 4'hF, 0, 0, 0, 0, 0, 4'hF, 0, 5'h00, 5'h10});
    repeat (2) @(negedge core_clk_i);
    check({4'h0, ind_code}, 8'h01, "reset indication");
    check({5'h00, tx_info}, 8'h00, "reset line info");
    rst_n_i = 1'b1;
    while (frame_tick !== 1'b1)
      @(negedge core_clk_i);
    t0 = cycles;
    @(negedge core_clk_i);
    while (frame_tick !== 1'b1)
      @(negedge core_clk_i);
    check(8'(cycles - t0), 8'(FL), "frame spacing");
    foreach (steps[i])
      run_step(i, steps[i]);
    print_verdict();
  end
endmodule : tb_top
